// File: spz_pkg.sv
/*
  Shared constants and types of the serial port block: register offsets on the APB
  side, control field layout, mode encodings, timer reload modes and shift patterns.
  Assumes a single clock domain and a 32-bit APB slave with byte addresses.
*/
`default_nettype none

package spz_pkg;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFF_CTRL = 8'h00;    // serial_control_reg.
  localparam logic [7:0] OFF_BUF = 8'h04;     // serial_buffer.
  localparam logic [7:0] OFF_POWER = 8'h08;   // power_control_reg.
  localparam logic [7:0] OFF_TMODE = 8'h0C;   // timer_mode_reg.
  localparam logic [7:0] OFF_RELOAD = 8'h10;  // t1_reload_high and t1_reload_low.
  localparam logic [7:0] OFF_RBYTE = 8'h14;   // t1_reload_byte.
  localparam logic [7:0] OFF_STATUS = 8'h18;  // Busy indications, read only.

  // Field positions and widths.
  localparam int unsigned POWER_DOUBLE_BIT = 7;  // rate_double_bit inside power_control_reg.
  localparam int unsigned TMODE_NIB_LSB = 4;     // Timer 1 nibble of timer_mode_reg.
  localparam int unsigned BYTE_W = 8;            // Data byte width.

  // Serial modes.
  localparam logic [1:0] MODE_SHIFT = 2'h0;   // Synchronous shift register.
  localparam logic [1:0] MODE_UART8 = 2'h1;   // 10-bit asynchronous frame.
  localparam logic [1:0] MODE_UART9F = 2'h2;  // Fixed-rate 9-bit mode, rate only.
  localparam logic [1:0] MODE_UART9V = 2'h3;  // Variable 9-bit mode, rate only.

  // Timer 1 nibble values that select the internal auto-reload counter.
  localparam logic [3:0] T1_AUTO8 = 4'h2;   // 8-bit reload, span 256.
  localparam logic [3:0] T1_AUTO16 = 4'h1;  // 16-bit reload, span 65536.
  localparam logic [7:0] T1_TOP8 = 8'hFF;
  localparam logic [15:0] T1_TOP16 = 16'hFFFF;

  // Shift register patterns.
  localparam logic [8:0] M0_RX_PRELOAD = 9'h1FE;  // 111111110.
  localparam logic [8:0] M1_RX_PRELOAD = 9'h1FF;
  localparam logic [7:0] TX_END_MARK = 8'h01;     // Marker just left of the MSB.

  // Divide-by-16 counter states; samples on the seventh, eighth and ninth.
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h6;
  localparam logic [3:0] SAMPLE_B = 4'h7;
  localparam logic [3:0] SAMPLE_C = 4'h8;

  // Control register layout, most significant field first.
  typedef struct packed {
    logic [1:0] mode;        // Serial mode select.
    logic multiproc_enable;  // Stop-bit qualification of receive.
    logic rx_enable;         // Receive enable.
    logic tx_ninth;          // Stored only; nine-bit modes are not framed here.
    logic rx_ninth_bit;      // Received stop bit in the 8-bit frame mode.
    logic tx_done_flag;      // Set by hardware at end of the last data bit.
    logic rx_done_flag;      // Set by hardware at end of receive.
  } spz_ctrl_t;

  // Bit order reversal, used by both receive paths.
  function automatic logic [7:0] spz_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : spz_rev8

endpackage : spz_pkg

`default_nettype wire

// File: spz_serial_port.sv
/*
  Serial port with bit-rate generation for all four modes and the framing of the
  shift register mode and the 8-bit asynchronous mode, reached over APB.
  Assumes one clock, which is also the oscillator, and an APB master on that clock.
*/
`default_nettype none

module spz_serial_port
  import spz_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_T1_OVF,
  input wire logic I_RXD,
  output logic O_RXD_OUT,
  output logic O_RXD_OE,
  output logic O_TXD
);

  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_SHIFT0, TX_REQ, TX_START, TX_DATA,
    TX_STOP} spz_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_M0_LOAD, RX_M0_ACT, RX_M1_ACT} spz_rx_state_t;

  spz_ctrl_t ctrl_q;             // Control and flag register.
  logic [7:0] rx_buf_q;          // Received byte, read side of the buffer.
  logic [7:0] power_q;           // Power control register.
  logic [7:0] tmode_q;           // Timer mode register.
  logic [7:0] reload_low_q;      // Low reload byte of the 16-bit timer.
  logic [7:0] reload_high_q;     // High reload byte of the 16-bit timer.
  logic [7:0] reload_byte_q;     // Reload byte of the 8-bit timer.
  logic [15:0] t1_cnt_q;         // Internal Timer 1 counter.
  logic t1_ovf;                  // Timer 1 overflow pulse.
  logic ovf_half_q;              // Halves the overflow rate when not doubled.
  logic pre_q;                   // Halves the oscillator for mode 2.
  logic tick16;                  // Sixteen times the bit rate.
  logic [3:0] tx_cnt_q;          // Transmit divide-by-16 counter.
  logic tx_roll;                 // Transmit bit boundary.
  logic [3:0] rx_cnt_q;          // Receive divide-by-16 counter.
  logic [8:0] tx_sr_q;           // Transmit shift register.
  logic [8:0] rx_sr_q;           // Receive shift register.
  logic [8:0] rx_next;           // Receive register after one more shift.
  spz_tx_state_t tx_state_q;
  spz_rx_state_t rx_state_q;
  logic sclk_q;                  // Mode 0 shift clock, low half first.
  logic m0_bit_q;                // Mode 0 bit taken at the rising shift clock.
  logic samp_a_q;                // First of the three mid-bit samples.
  logic samp_b_q;                // Second of the three mid-bit samples.
  logic majority;                // Accepted bit value.
  logic rx_prev_q;               // Line value at the previous tick.
  logic rxd_s1_q;                // Synchroniser, first stage.
  logic rxd_s2_q;                // Synchroniser, second stage.
  logic [31:0] prdata_q;
  logic wr_access;
  logic sel_ctrl, sel_buf, sel_power, sel_tmode, sel_reload, sel_rbyte, sel_status;
  logic mapped;
  logic rate_double;
  logic tx_end;                  // Marker pattern seen at the shift position.
  logic ti_set;                  // Transmit done event.
  logic rx_load;                 // Buffer load and receive done event.
  logic [7:0] rx_byte;           // Byte to load into the buffer.
  logic tx_line;                 // Next transmit pin value.
  logic rxd_line;                // Next receive pin drive value.
  logic rxd_drive;               // Next receive pin enable.

  assign rate_double = power_q[POWER_DOUBLE_BIT];

  // Address decode, shared by the read path and the write path.
  always_comb begin
    sel_ctrl = 1'b0;
    sel_buf = 1'b0;
    sel_power = 1'b0;
    sel_tmode = 1'b0;
    sel_reload = 1'b0;
    sel_rbyte = 1'b0;
    sel_status = 1'b0;
    if (I_PADDR == OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (I_PADDR == OFF_BUF) begin
      sel_buf = 1'b1;
    end else if (I_PADDR == OFF_POWER) begin
      sel_power = 1'b1;
    end else if (I_PADDR == OFF_TMODE) begin
      sel_tmode = 1'b1;
    end else if (I_PADDR == OFF_RELOAD) begin
      sel_reload = 1'b1;
    end else if (I_PADDR == OFF_RBYTE) begin
      sel_rbyte = 1'b1;
    end else if (I_PADDR == OFF_STATUS) begin
      sel_status = 1'b1;
    end
  end

  assign mapped = sel_ctrl | sel_buf | sel_power | sel_tmode | sel_reload | sel_rbyte |
    sel_status;
  // The slave never stalls, so every access completes in its first access cycle.
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
  assign wr_access = I_PSEL & I_PENABLE & I_PWRITE & mapped;
  assign O_PRDATA = prdata_q;

  // Read data is captured in the setup cycle, so it stands steady during access.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      prdata_q <= 32'h0000_0000;
      if (sel_ctrl) begin
        prdata_q[7:0] <= ctrl_q;
      end else if (sel_buf) begin
        prdata_q[7:0] <= rx_buf_q;
      end else if (sel_power) begin
        prdata_q[7:0] <= power_q;
      end else if (sel_tmode) begin
        prdata_q[7:0] <= tmode_q;
      end else if (sel_reload) begin
        prdata_q[15:0] <= {reload_high_q, reload_low_q};
      end else if (sel_rbyte) begin
        prdata_q[7:0] <= reload_byte_q;
      end else if (sel_status) begin
        prdata_q[1:0] <= {rx_state_q != RX_IDLE, tx_state_q != TX_IDLE};
      end
    end
  end

  // Rate and timer configuration registers, plain storage.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      power_q <= 8'h00;
      tmode_q <= 8'h00;
      reload_low_q <= 8'h00;
      reload_high_q <= 8'h00;
      reload_byte_q <= 8'h00;
    end else if (wr_access) begin
      if (sel_power) begin
        power_q <= I_PWDATA[7:0];
      end
      if (sel_tmode) begin
        tmode_q <= I_PWDATA[7:0];
      end
      if (sel_reload) begin
        reload_low_q <= I_PWDATA[7:0];
        reload_high_q <= I_PWDATA[15:8];
      end
      if (sel_rbyte) begin
        reload_byte_q <= I_PWDATA[7:0];
      end
    end
  end

  // Control register; a hardware set in the same cycle as a software clear wins.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_q <= '0;
      rx_buf_q <= 8'h00;
    end else begin
      if (wr_access && sel_ctrl) begin
        ctrl_q <= spz_ctrl_t'(I_PWDATA[7:0]);
      end
      if (ti_set) begin
        ctrl_q.tx_done_flag <= 1'b1;
      end
      if (rx_load) begin
        rx_buf_q <= rx_byte;
        ctrl_q.rx_done_flag <= 1'b1;
        if (ctrl_q.mode == MODE_UART8) begin
          ctrl_q.rx_ninth_bit <= majority;
        end
      end
    end
  end

  // Timer 1 stand-in: counts the oscillator up to overflow and reloads, so the
  // overflow period is the span minus the reload value. Other nibbles use the input.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      t1_cnt_q <= 16'h0000;
    end else if (tmode_q[TMODE_NIB_LSB +: 4] == T1_AUTO8) begin
      if (t1_cnt_q[7:0] == T1_TOP8) begin
        t1_cnt_q <= {8'h00, reload_byte_q};
      end else begin
        t1_cnt_q <= {8'h00, t1_cnt_q[7:0] + 8'h01};
      end
    end else if (tmode_q[TMODE_NIB_LSB +: 4] == T1_AUTO16) begin
      if (t1_cnt_q == T1_TOP16) begin
        t1_cnt_q <= {reload_high_q, reload_low_q};
      end else begin
        t1_cnt_q <= t1_cnt_q + 16'h0001;
      end
    end
  end

  always_comb begin
    if (tmode_q[TMODE_NIB_LSB +: 4] == T1_AUTO8) begin
      t1_ovf = (t1_cnt_q[7:0] == T1_TOP8);
    end else if (tmode_q[TMODE_NIB_LSB +: 4] == T1_AUTO16) begin
      t1_ovf = (t1_cnt_q == T1_TOP16);
    end else begin
      t1_ovf = I_T1_OVF;
    end
  end

  // Prescalers for the sixteen-times tick.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pre_q <= 1'b0;
      ovf_half_q <= 1'b0;
    end else begin
      pre_q <= ~pre_q;
      if (t1_ovf) begin
        ovf_half_q <= ~ovf_half_q;
      end
    end
  end

  // Sixteen ticks make one bit; mode 0 runs from the shift clock instead.
  always_comb begin
    tick16 = 1'b0;
    if (ctrl_q.mode == MODE_UART9F) begin
      tick16 = rate_double | pre_q;
    end else if (ctrl_q.mode != MODE_SHIFT) begin
      tick16 = t1_ovf & (rate_double | ovf_half_q);
    end
  end

  // Transmit divide-by-16 counter runs freely so bit times ignore the write moment.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_cnt_q <= 4'h0;
    end else if (tick16) begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
    end
  end
  assign tx_roll = tick16 && (tx_cnt_q == DIV16_LAST);

  // Shift clock toggles every oscillator cycle while mode 0 is moving data.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sclk_q <= 1'b0;
    end else if (tx_state_q == TX_SHIFT0 || rx_state_q == RX_M0_ACT) begin
      sclk_q <= ~sclk_q;
    end else begin
      sclk_q <= 1'b0;
    end
  end

  assign tx_end = (tx_sr_q[8:1] == TX_END_MARK);
  assign ti_set = (tx_state_q == TX_SHIFT0 && sclk_q && tx_end) ||
    (tx_state_q == TX_DATA && tx_roll && tx_end);

  // Transmit sequencer. A buffer write while busy is ignored.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_state_q <= TX_IDLE;
      tx_sr_q <= 9'h000;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (wr_access && sel_buf) begin
            tx_sr_q <= {1'b1, I_PWDATA[BYTE_W-1:0]};
            if (ctrl_q.mode == MODE_SHIFT) begin
              tx_state_q <= TX_WAIT;
            end else if (ctrl_q.mode == MODE_UART8) begin
              tx_state_q <= TX_REQ;
            end
          end
        end
        TX_WAIT: begin
          tx_state_q <= TX_SHIFT0;
        end
        TX_SHIFT0: begin
          if (sclk_q) begin
            tx_sr_q <= {1'b0, tx_sr_q[8:1]};
            if (tx_end) begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        TX_REQ: begin
          if (tx_roll) begin
            tx_state_q <= TX_START;
          end
        end
        TX_START: begin
          if (tx_roll) begin
            tx_state_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_roll && tx_state_q == TX_DATA) begin
            tx_sr_q <= {1'b0, tx_sr_q[8:1]};
            if (tx_end) begin
              tx_state_q <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (tx_roll) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Receive line synchroniser.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= I_RXD;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // Two of three samples decide the bit; the third is the live sample.
  assign majority = (samp_a_q & samp_b_q) | (samp_a_q & rxd_s2_q) |
    (samp_b_q & rxd_s2_q);
  assign rx_next = (rx_state_q == RX_M0_ACT) ? {rx_sr_q[7:0], m0_bit_q} :
    {rx_sr_q[7:0], majority};

  // Buffer load conditions for both receive modes.
  always_comb begin
    rx_load = 1'b0;
    rx_byte = spz_rev8(rx_next[7:0]);
    if (rx_state_q == RX_M0_ACT && sclk_q && !rx_next[8]) begin
      rx_load = 1'b1;
    end else if (rx_state_q == RX_M1_ACT && tick16 && rx_cnt_q == SAMPLE_C &&
        !rx_sr_q[8]) begin
      rx_byte = spz_rev8(rx_next[8:1]);
      rx_load = !ctrl_q.rx_done_flag && (!ctrl_q.multiproc_enable || majority);
    end
  end

  // Receive sequencer for both modes.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_state_q <= RX_IDLE;
      rx_sr_q <= 9'h000;
      rx_cnt_q <= 4'h0;
      m0_bit_q <= 1'b0;
      samp_a_q <= 1'b1;
      samp_b_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      if (tick16) begin
        rx_prev_q <= rxd_s2_q;
      end
      case (rx_state_q)
        RX_IDLE: begin
          if (ctrl_q.mode == MODE_SHIFT && ctrl_q.rx_enable && !ctrl_q.rx_done_flag &&
              tx_state_q == TX_IDLE) begin
            rx_state_q <= RX_M0_LOAD;
          end else if (ctrl_q.mode == MODE_UART8 && ctrl_q.rx_enable && tick16 &&
              rx_prev_q && !rxd_s2_q) begin
            rx_cnt_q <= 4'h0;
            rx_sr_q <= M1_RX_PRELOAD;
            rx_state_q <= RX_M1_ACT;
          end
        end
        RX_M0_LOAD: begin
          rx_sr_q <= M0_RX_PRELOAD;
          rx_state_q <= RX_M0_ACT;
        end
        RX_M0_ACT: begin
          if (!sclk_q) begin
            m0_bit_q <= rxd_s2_q;
          end else begin
            rx_sr_q <= rx_next;
            if (!rx_next[8]) begin
              rx_state_q <= RX_IDLE;
            end
          end
        end
        RX_M1_ACT: begin
          if (tick16) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == SAMPLE_A) begin
              samp_a_q <= rxd_s2_q;
            end else if (rx_cnt_q == SAMPLE_B) begin
              samp_b_q <= rxd_s2_q;
            end else if (rx_cnt_q == SAMPLE_C) begin
              rx_sr_q <= rx_next;
              if (rx_sr_q == M1_RX_PRELOAD && majority) begin
                rx_state_q <= RX_IDLE;
              end else if (!rx_sr_q[8]) begin
                rx_state_q <= RX_IDLE;
              end
            end
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Pin values: in mode 0 the receive pin carries data and the transmit pin the clock.
  always_comb begin
    tx_line = 1'b1;
    rxd_line = 1'b1;
    rxd_drive = 1'b0;
    if (tx_state_q == TX_SHIFT0) begin
      tx_line = sclk_q;
      rxd_line = tx_sr_q[0];
      rxd_drive = 1'b1;
    end else if (rx_state_q == RX_M0_ACT) begin
      tx_line = sclk_q;
    end else if (tx_state_q == TX_START) begin
      tx_line = 1'b0;
    end else if (tx_state_q == TX_DATA) begin
      tx_line = tx_sr_q[0];
    end
  end

  // Pins are registered to keep them glitch free; they lag the state by one clock.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TXD <= 1'b1;
      O_RXD_OUT <= 1'b1;
      O_RXD_OE <= 1'b0;
    end else begin
      O_TXD <= tx_line;
      O_RXD_OUT <= rxd_line;
      O_RXD_OE <= rxd_drive;
    end
  end

endmodule : spz_serial_port

`default_nettype wire

// File: spz_monitor.sv
/*
  Checker of the serial port pins and of the APB answers.
  Assumes it is bound to spz_serial_port and sees only its ports.
*/
`default_nettype none

module spz_monitor (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_T1_OVF,
  input wire logic I_RXD,
  input wire logic O_RXD_OUT,
  input wire logic O_RXD_OE,
  input wire logic O_TXD
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  // Shift clock falls counted while the data pin is driven.
  logic [3:0] fall_q;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      fall_q <= 4'h0;
    end else if (!O_RXD_OE) begin
      fall_q <= 4'h0;
    end else if ($fell(O_TXD)) begin
      fall_q <= fall_q + 4'h1;
    end
  end

  AST_M0_HALF_CLK: assert property (O_RXD_OE && $fell(O_TXD) |=> O_TXD)
    else $error("shift clock low for more than one clock");
  AST_M0_LOW_FIRST: assert property ($rose(O_RXD_OE) |-> ##[0:1] !O_TXD)
    else $error("shift clock did not open low");
  AST_M0_EIGHT_FALLS: assert property ($fell(O_RXD_OE) |-> fall_q == 4'h8)
    else $error("send ended without eight shift clocks");
  AST_M0_SPAN: assert property ($rose(O_RXD_OE) |-> O_RXD_OE [*8] ##[8:11] !O_RXD_OE)
    else $error("send length wrong");
  AST_APB_READY: assert property (O_PREADY)
    else $error("ready low");
  AST_APB_UNMAPPED: assert property (I_PSEL && I_PENABLE && I_PADDR > 8'h18 |-> O_PSLVERR)
    else $error("no error on unmapped access");
  AST_APB_ERR_ACCESS: assert property (!(I_PSEL && I_PENABLE) |-> !O_PSLVERR)
    else $error("error outside access phase");
  AST_PRDATA_HOLD: assert property (!(I_PSEL && !I_PENABLE) |=> $stable(O_PRDATA))
    else $error("read data moved without setup");
  AST_PRDATA_UPPER: assert property (O_PRDATA[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule : spz_monitor

bind spz_serial_port spz_monitor spz_monitor_inst (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_T1_OVF(I_T1_OVF), .I_RXD(I_RXD),
  .O_RXD_OUT(O_RXD_OUT), .O_RXD_OE(O_RXD_OE), .O_TXD(O_TXD)
);

`default_nettype wire

// File: spz_partner.sv
/*
  Far-end asynchronous transceiver: frames bytes onto the receive pin, decodes the transmit pin.
  Assumes the serial port's clock and a bit time given in clocks.
*/
`default_nettype none

module spz_partner (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line rests high between frames, as a pulled-up line would.
  initial o_rxd = 1'b1;

  // One frame, then one idle bit so the next start edge is clean.
  task automatic send(input logic [7:0] b, input logic stp, input int bt);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd <= f[i];
      repeat (bt) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    repeat (bt) @(posedge i_clk);
  endtask : send

  // A short low pulse that must not pass for a start bit.
  task automatic glitch(input int n);
    o_rxd <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_rxd <= 1'b1;
    repeat (64) @(posedge i_clk);
  endtask : glitch

  // Samples mid-bit at negedges, where the pin has settled. The start search is long
  // because the 16-bit reload timer may count a full span before its first overflow.
  task automatic recv(output logic [7:0] b, output logic stp, input int bt, output logic ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    stp = 1'b0;
    n = 0;
    while (i_txd !== 1'b0 && n < 70000) begin
      @(negedge i_clk);
      n++;
    end
    repeat (bt / 2) @(negedge i_clk);
    ok = (i_txd === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(negedge i_clk);
      b[i] = i_txd;
    end
    repeat (bt) @(negedge i_clk);
    stp = i_txd;
  endtask : recv
endmodule : spz_partner

`default_nettype wire

// File: tb_top.sv
/*
  Self-checking bench of the serial port: APB master, mode 0 and mode 1 traffic.
  Assumes spz_partner as the far end and the checker bound to the design.
*/
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top
  import spz_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ovf = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, rxd_out, rxd_oe, txd, far_rxd;
  wire logic pin; // Resolved level of the shared data pin.
  int mismatches = 0;
  int compares = 0;
  int ovf_per = 4;
  int ovf_cnt = 0;

  initial forever #12.5 clk = ~clk;
  assign pin = rxd_oe ? rxd_out : far_rxd;

  spz_serial_port spz_serial_port_inst (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_T1_OVF(ovf),
    .I_RXD(pin), .O_RXD_OUT(rxd_out), .O_RXD_OE(rxd_oe), .O_TXD(txd));
  spz_partner spz_partner_inst (.i_clk(clk), .i_txd(txd), .o_rxd(far_rxd));

  // External overflow pulses; no timer interrupt exists on this bench.
  always @(posedge clk) begin
    ovf_cnt <= (ovf_cnt + 1) % ovf_per;
    ovf <= (ovf_cnt == 0);
  end

  task automatic close_out();
    $display("Counts: compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // One APB transfer, held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    `CHK(r, x)
  endtask : rdc

  task automatic t_reset();
    logic [31:0] r;
    logic e;
    logic [7:0] offs[7] = '{OFF_CTRL, OFF_BUF, OFF_POWER, OFF_TMODE, OFF_RELOAD,
                            OFF_RBYTE, OFF_STATUS};
    foreach (offs[i]) rdc(offs[i], 32'h00000000);
    `CHK({txd, rxd_oe}, 2'b10)
    apb(1'b0, 8'h1C, 32'h00000000, r, e);
    `CHK({e, r}, {1'b1, 32'h00000000})
    $display("test reset done");
  endtask : t_reset

  // Mode 0 send: bits read on each rising shift clock from the pin.
  task automatic t_m0_tx();
    logic [7:0] got;
    logic pt;
    int k;
    int n;
    got = 8'h00;
    pt = 1'b1;
    k = 0;
    n = 0;
    wr(OFF_BUF, 32'h0000004B);
    while (k < 8 && n < 200) begin
      @(negedge clk);
      n++;
      if (rxd_oe === 1'b1 && pt === 1'b0 && txd === 1'b1) begin
        got[k] = pin;
        k++;
      end
      pt = txd;
    end
    if (n >= 200) begin mismatches++; close_out(); end
    `CHK(got, 8'h4B)
    repeat (8) @(posedge clk);
    rdc(OFF_CTRL, 32'h00000002);
    $display("test mode0 send done");
  endtask : t_m0_tx

  // Mode 1 send at three rate sources: 8-bit, 16-bit reload, external overflow.
  task automatic t_m1_tx();
    logic [7:0] b;
    logic s;
    logic ok;
    logic [7:0] tm[3] = '{8'h20, 8'h10, 8'h00};
    logic [7:0] pw[3] = '{8'h80, 8'h00, 8'h80};
    int bt[3] = '{32, 96, 64};
    wr(OFF_RBYTE, 32'h000000FE);
    wr(OFF_RELOAD, 32'h0000FFFD);
    wr(OFF_CTRL, 32'h00000040);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_TMODE, {24'h000000, tm[i]});
      wr(OFF_POWER, {24'h000000, pw[i]});
      fork
        spz_partner_inst.recv(b, s, bt[i], ok);
        wr(OFF_BUF, {24'h000000, 8'hC5 ^ 8'(i)});
      join
      `CHK({ok, s, b}, {2'b11, 8'hC5 ^ 8'(i)})
      if (ok !== 1'b1) close_out();
      rdc(OFF_CTRL, 32'h00000042);
      rdc(OFF_STATUS, 32'h00000001);
      repeat (bt[i]) @(posedge clk);
      wr(OFF_CTRL, 32'h00000040);
    end
    $display("test mode1 send done");
  endtask : t_m1_tx

  // Mode 1 receive: false start, good frame, held flag, stop qualification.
  task automatic t_m1_rx();
    wr(OFF_TMODE, 32'h00000020);
    wr(OFF_POWER, 32'h00000080);
    wr(OFF_CTRL, 32'h00000050);
    spz_partner_inst.glitch(4);
    spz_partner_inst.send(8'h3C, 1'b1, 32);
    rdc(OFF_BUF, 32'h0000003C);
    rdc(OFF_CTRL, 32'h00000055);
    spz_partner_inst.send(8'hC3, 1'b1, 32);
    rdc(OFF_BUF, 32'h0000003C);
    wr(OFF_CTRL, 32'h00000070);
    spz_partner_inst.send(8'h5A, 1'b0, 32);
    rdc(OFF_CTRL, 32'h00000070);
    spz_partner_inst.send(8'h5A, 1'b1, 32);
    rdc(OFF_BUF, 32'h0000005A);
    rdc(OFF_CTRL, 32'h00000075);
    $display("test mode1 receive done");
  endtask : t_m1_rx

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_m0_tx();
    t_m1_tx();
    t_m1_rx();
    close_out();
  end

  // A hang counts against the run and still reaches the report.
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule : tb_top

`default_nettype wire
